/* File: pkg/ldpf_defines.vh */
// Purpose: Shared constants of the LED dimming and fault monitor block
// Assumes: 8-bit register port, 250 MHz core clock
// Notes: Offsets are byte addresses on the plain register port
`ifndef LDPF_DEFINES_VH
`define LDPF_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LDPF_A_CFG 8'h00
`define LDPF_A_PHASE 8'h03
`define LDPF_A_DUTY_LO 8'h26
`define LDPF_A_DUTY_HI 8'h40
`define LDPF_A_THR_LO 8'h41
`define LDPF_A_THR_HI 8'h49
`define LDPF_A_SSC 8'h4a
`define LDPF_A_SMODE 8'h4b
`define LDPF_A_FDE 8'h4c
`define LDPF_A_FCFG 8'h4d
`define LDPF_A_SHORT 8'h4e
`define LDPF_A_OPEN 8'h51
`define LDPF_A_SLS 8'h54
`define LDPF_A_SUM 8'h57
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define LDPF_RST_CFG 8'h00
`define LDPF_RST_PHASE 8'h01
`define LDPF_MODE_12 2'h0
`define LDPF_MODE_75 2'h1
`define LDPF_MODE_8 2'h2
`define LDPF_SUM_OPEN 0
`define LDPF_SUM_SHORT 1
`define LDPF_SUM_SLS 2
`define LDPF_SUM_PIN 7
// ----------------------------------------
// Timing
// ----------------------------------------
`define LDPF_CLK_NS 4
`define LDPF_DEGLITCH_NS 10000
`define LDPF_DEGLITCH_CYC ((`LDPF_DEGLITCH_NS + `LDPF_CLK_NS - 1) / `LDPF_CLK_NS)
`define LDPF_RPT_UNIT_NS 100000
`define LDPF_RPT_UNIT_CYC (`LDPF_RPT_UNIT_NS / `LDPF_CLK_NS)
`define LDPF_BASE_DIV 11'h050
`endif

/* File: design/ldpf_top.v */
// Purpose: Eighteen-channel PWM dimming with open/short fault monitor
// Assumes: Comparator results and supply-ok level are asynchronous
// Notes: Retry current level itself is applied by the analog sink
// ----------------------------------------
// How it works
// RULE1: Each of eighteen channels has its own 12-bit PWM generator.
// RULE2: Sink is on during the on-phase, off for the rest of period.
// RULE3: Duty values come from duty registers at 0x26 to 0x40.
// RULE4: 12-bit and 7+5 modes use value/4096; 8-bit mode uses bits 11:4 over 256.
// RULE5: Frequency select sits in the configuration register at 0x00.
// RULE6: Spread spectrum on the base clock is switched by register 0x4a.
// RULE7: Phase control 0x00 turns all channels on together each cycle.
// RULE8: Phase control resets to 0x01, stagger on.
// RULE9: Six groups of three consecutive channels.
// RULE10: With stagger on, groups start one after another.
// RULE11: Offsets 1->2, 3->4, 5->6, 6->1 are one eighth period.
// RULE12: Offsets 2->3 and 4->5 are one quarter period.
// RULE13: A fault sets its type flag; pin pulls low after report delay.
// RULE14: Open check runs only when both open enable bits are set.
// RULE15: Open for 10 us sets channel flag, sticky summary and retry.
// RULE16: Open gone clears channel flag; pin released after delay; summary stays.
// RULE17: Checks run only in on-phase; on-time under 10 us reports nothing.
// RULE18: Short for 10 us with both enables sets flags, summary and retry.
// RULE19: Short gone clears channel flag; pin released; summary stays.
// RULE20: Single short check waits for supply above fault undervoltage level.
// RULE21: Each channel has a 5-bit single short threshold code in 0x41-0x49; the code holds only nine codes, one per register.
// RULE22: Single short for 10 us sets flag from 0x54, summary and retry.
// RULE23: Single short gone clears flag; pin released; summary stays.
// RULE24: Comparators are synchronised; deglitch and delay use core counters.
//
// Design decision made here: the strobed register port.
`include "ldpf_defines.vh"
module ldpf_top #(
  parameter RPT_UNIT_CYC = `LDPF_RPT_UNIT_CYC
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire [17:0] open_cmp_i,
  input wire [17:0] short_cmp_i,
  input wire [17:0] sls_cmp_i,
  input wire supply_ok_i,
  output reg [17:0] channel_sink_output_o,
  output reg [17:0] retry_current_o,
  output wire [2:0] string_short_mode_select_o,
  output wire [44:0] single_short_threshold_code_o,
  input wire fault_report_pin_n_i,
  output wire fault_report_pin_n_o,
  output wire fault_report_pin_n_oe_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] cfg_q;
  reg [7:0] phase_q;
  reg [7:0] duty_mem [0:26];
  reg [4:0] thr_mem [0:8];
  reg ssc_q;
  reg [2:0] smode_q;
  reg [5:0] fde_q;
  reg [3:0] ft_q;
  reg [2:0] sum_q;
  reg [2:0] sum_d;
  reg [7:0] rdata_d;
  integer k;

  wire [1:0] mode = cfg_q[1:0];
  wire [1:0] fsel = cfg_q[3:2];
  wire phase_stagger_on = phase_q[0];
  wire open_on = fde_q[0] & fde_q[1]; // RULE14
  wire short_on = fde_q[2] & fde_q[3]; // RULE18
  wire sls_on = fde_q[4] & fde_q[5];

  wire wr_duty = reg_wr_i && reg_addr_i >= `LDPF_A_DUTY_LO && reg_addr_i <= `LDPF_A_DUTY_HI;
  wire wr_thr = reg_wr_i && reg_addr_i >= `LDPF_A_THR_LO && reg_addr_i <= `LDPF_A_THR_HI;
  wire [7:0] duty_idx = reg_addr_i - `LDPF_A_DUTY_LO;
  wire [7:0] thr_idx = reg_addr_i - `LDPF_A_THR_LO;

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= `LDPF_RST_CFG;
      phase_q <= `LDPF_RST_PHASE; // RULE8
      ssc_q <= 1'b0;
      smode_q <= 3'h0;
      fde_q <= 6'h00;
      ft_q <= 4'h0;
      for (k = 0; k < 27; k = k + 1) begin
        duty_mem[k] <= 8'h00;
      end
      for (k = 0; k < 9; k = k + 1) begin
        thr_mem[k] <= 5'h00;
      end
    end else begin
      if (reg_wr_i && reg_addr_i == `LDPF_A_CFG) begin
        cfg_q <= reg_wdata_i; // RULE5
      end
      if (reg_wr_i && reg_addr_i == `LDPF_A_PHASE) begin
        phase_q <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `LDPF_A_SSC) begin
        ssc_q <= reg_wdata_i[0]; // RULE6
      end
      if (reg_wr_i && reg_addr_i == `LDPF_A_SMODE) begin
        smode_q <= reg_wdata_i[2:0];
      end
      if (reg_wr_i && reg_addr_i == `LDPF_A_FDE) begin
        fde_q <= reg_wdata_i[5:0];
      end
      if (reg_wr_i && reg_addr_i == `LDPF_A_FCFG) begin
        ft_q <= reg_wdata_i[3:0];
      end
      if (wr_duty) begin
        duty_mem[duty_idx[4:0]] <= reg_wdata_i; // RULE3
      end
      if (wr_thr) begin
        thr_mem[thr_idx[3:0]] <= reg_wdata_i[4:0]; // RULE21
      end
    end
  end

  assign string_short_mode_select_o = smode_q;

  // ----------------------------------------
  // Base clock with spread spectrum
  // ----------------------------------------
  reg [10:0] pre_q;
  reg [11:0] cnt_q;
  reg [2:0] dith_q;
  reg dith_up_q;
  wire [10:0] lim = (`LDPF_BASE_DIV << fsel) + {8'h00, (ssc_q ? dith_q : 3'h0)};
  wire tick = (pre_q >= lim);

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_q <= 11'h000;
      cnt_q <= 12'h000;
      dith_q <= 3'h0;
      dith_up_q <= 1'b1;
    end else begin
      pre_q <= tick ? 11'h000 : pre_q + 11'h001;
      if (tick) begin
        cnt_q <= cnt_q + 12'h001;
      end
      // Triangle sweep of the divider, one step per full count
      if (tick && cnt_q == 12'hfff) begin // RULE6
        if (dith_up_q) begin
          dith_q <= dith_q + 3'h1;
          dith_up_q <= (dith_q != 3'h6);
        end else begin
          dith_q <= dith_q - 3'h1;
          dith_up_q <= (dith_q == 3'h1);
        end
      end
    end
  end

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  reg [54:0] sy1_q;
  reg [54:0] sy2_q;
  reg pin1_q;
  reg pin2_q;
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sy1_q <= 55'h0;
      sy2_q <= 55'h0;
      pin1_q <= 1'b1;
      pin2_q <= 1'b1;
    end else begin
      sy1_q <= {supply_ok_i, sls_cmp_i, short_cmp_i, open_cmp_i}; // RULE24
      sy2_q <= sy1_q;
      pin1_q <= fault_report_pin_n_i;
      pin2_q <= pin1_q;
    end
  end
  wire uv_ok = sy2_q[54];

  // ----------------------------------------
  // Sink state aligned with the synchronisers
  // ----------------------------------------
  // Comparator readings lag the sink by the sync stages; a stale off-phase
  // reading must not count as a cleared fault at the start of an on-phase
  reg [17:0] sink1_q;
  reg [17:0] sink2_q;
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sink1_q <= 18'h00000;
      sink2_q <= 18'h00000;
    end else begin
      sink1_q <= channel_sink_output_o;
      sink2_q <= sink1_q; // RULE17
    end
  end

  // ----------------------------------------
  // Per-channel PWM
  // ----------------------------------------
  wire [17:0] on_d;
  genvar c;
  generate
    for (c = 0; c < 18; c = c + 1) begin : g_ch // RULE1
      localparam G = c / 3; // RULE9
      localparam [2:0] OFS = (G == 0) ? 3'd0 : (G == 1) ? 3'd1 : (G == 2) ? 3'd3 :
                             (G == 3) ? 3'd4 : (G == 4) ? 3'd6 : 3'd7; // RULE11 RULE12
      localparam P = c / 2;
      wire [11:0] duty;
      if (c % 2 == 0) begin : g_ev
        assign duty = {duty_mem[3 * P], duty_mem[3 * P + 2][7:4]};
      end else begin : g_od
        assign duty = {duty_mem[3 * P + 1], duty_mem[3 * P + 2][3:0]};
      end
      wire [2:0] ofs = phase_stagger_on ? OFS : 3'd0; // RULE7 RULE10
      wire [11:0] ph12 = cnt_q - {ofs, 9'h000};
      wire [7:0] ph8 = cnt_q[7:0] - {ofs, 5'h00};
      wire [6:0] ph7 = cnt_q[6:0] - {ofs, 4'h0};
      wire [7:0] on75 = {1'b0, duty[11:5]} + {7'h00, (cnt_q[11:7] < duty[4:0])};
      assign on_d[c] = (mode == `LDPF_MODE_8) ? (ph8 < duty[11:4]) : // RULE4
                       (mode == `LDPF_MODE_75) ? ({1'b0, ph7} < on75) :
                       (ph12 < duty); // RULE2
    end
  endgenerate

  // ----------------------------------------
  // Deglitch and per-channel flags
  // ----------------------------------------
  // Entry i: type i/18 (open, short, single short), channel i%18
  wire [53:0] flag;
  wire [53:0] set_ev;
  genvar i;
  generate
    for (i = 0; i < 54; i = i + 1) begin : g_det
      localparam T = i / 18;
      localparam CH = i % 18;
      reg [11:0] dg_q;
      reg flag_q;
      wire en = (T == 0) ? open_on : (T == 1) ? short_on : (sls_on & uv_ok); // RULE20
      wire qual = en & sink2_q[CH]; // RULE17
      wire cmp = sy2_q[i];
      wire hit = qual & cmp & (dg_q == `LDPF_DEGLITCH_CYC - 1);
      always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          dg_q <= 12'h000;
          flag_q <= 1'b0;
        end else begin
          // Off-phase restarts the count, so short pulses never report
          if (!(qual & cmp)) begin
            dg_q <= 12'h000; // RULE17
          end else if (dg_q != `LDPF_DEGLITCH_CYC - 1) begin
            dg_q <= dg_q + 12'h001; // RULE24
          end
          if (!en) begin
            flag_q <= 1'b0;
          end else if (hit) begin
            flag_q <= 1'b1; // RULE15 RULE18 RULE22
          end else if (qual & ~cmp) begin
            flag_q <= 1'b0; // RULE16 RULE19 RULE23
          end
        end
      end
      assign flag[i] = flag_q;
      assign set_ev[i] = hit & ~flag_q;
    end
  endgenerate

  // ----------------------------------------
  // Summary, retry and sink outputs
  // ----------------------------------------
  wire [17:0] f_open = flag[17:0];
  wire [17:0] f_short = flag[35:18];
  wire [17:0] f_sls = flag[53:36];
  wire wr_sum = reg_wr_i && reg_addr_i == `LDPF_A_SUM;

  always @* begin
    sum_d = sum_q;
    if (wr_sum) begin
      sum_d = sum_q & reg_wdata_i[2:0];
    end
    // Set wins over a clear in the same cycle
    sum_d[`LDPF_SUM_OPEN] = sum_d[`LDPF_SUM_OPEN] | (|set_ev[17:0]); // RULE15
    sum_d[`LDPF_SUM_SHORT] = sum_d[`LDPF_SUM_SHORT] | (|set_ev[35:18]); // RULE18
    sum_d[`LDPF_SUM_SLS] = sum_d[`LDPF_SUM_SLS] | (|set_ev[53:36]); // RULE22
  end

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sum_q <= 3'h0;
      channel_sink_output_o <= 18'h0;
      retry_current_o <= 18'h0;
    end else begin
      sum_q <= sum_d; // RULE13
      channel_sink_output_o <= on_d; // RULE2
      retry_current_o <= f_open | f_short | f_sls; // RULE15 RULE18 RULE22
    end
  end

  // ----------------------------------------
  // Fault pin report delay
  // ----------------------------------------
  reg pin_low_q;
  reg [19:0] rdly_q;
  wire any_flt = |flag;
  wire [31:0] rdly_full = ft_q * RPT_UNIT_CYC;
  wire [19:0] rdly_lim = rdly_full[19:0];
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_low_q <= 1'b0;
      rdly_q <= 20'h00000;
    end else if (any_flt == pin_low_q) begin
      rdly_q <= 20'h00000;
    end else if (rdly_q >= rdly_lim) begin
      pin_low_q <= any_flt; // RULE13 RULE16 RULE19 RULE23
      rdly_q <= 20'h00000;
    end else begin
      rdly_q <= rdly_q + 20'h00001; // RULE24
    end
  end
  assign fault_report_pin_n_o = 1'b0;
  assign fault_report_pin_n_oe_o = pin_low_q;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  function [7:0] byte18;
    input [17:0] v;
    input [1:0] s;
    begin
      byte18 = (s == 2'd0) ? v[7:0] : (s == 2'd1) ? v[15:8] : {6'h00, v[17:16]};
    end
  endfunction

  genvar t;
  generate
    for (t = 0; t < 9; t = t + 1) begin : g_thr
      assign single_short_threshold_code_o[5 * t +: 5] = thr_mem[t]; // RULE21
    end
  endgenerate

  wire [7:0] a = reg_addr_i;
  always @* begin
    rdata_d = 8'h00;
    if (a >= `LDPF_A_DUTY_LO && a <= `LDPF_A_DUTY_HI) begin
      rdata_d = duty_mem[duty_idx[4:0]];
    end else if (a >= `LDPF_A_THR_LO && a <= `LDPF_A_THR_HI) begin
      rdata_d = {3'h0, thr_mem[thr_idx[3:0]]};
    end else if (a >= `LDPF_A_SHORT && a < `LDPF_A_OPEN) begin
      rdata_d = byte18(f_short, a[1:0] - 2'd2);
    end else if (a >= `LDPF_A_OPEN && a < `LDPF_A_SLS) begin
      rdata_d = byte18(f_open, a[1:0] - 2'd1);
    end else if (a >= `LDPF_A_SLS && a < `LDPF_A_SUM) begin
      rdata_d = byte18(f_sls, a[1:0]);
    end else begin
      case (a)
        `LDPF_A_CFG: rdata_d = cfg_q;
        `LDPF_A_PHASE: rdata_d = phase_q;
        `LDPF_A_SSC: rdata_d = {7'h00, ssc_q};
        `LDPF_A_SMODE: rdata_d = {5'h00, smode_q};
        `LDPF_A_FDE: rdata_d = {2'h0, fde_q};
        `LDPF_A_FCFG: rdata_d = {4'h0, ft_q};
        `LDPF_A_SUM: rdata_d = {pin2_q, 4'h0, sum_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end
endmodule

/* File: dv/ldpf_props.sv */
// Purpose: Port checker for ldpf_top
// Assumes: One clock, async reset high
// Notes: Fault scenarios use channel bit 5
module ldpf_props #(
  parameter RPT_UNIT_CYC = 4
) (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire [17:0] channel_sink_output_o,
  input wire [17:0] retry_current_o,
  input wire [2:0] string_short_mode_select_o,
  input wire fault_report_pin_n_o,
  input wire fault_report_pin_n_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RWIN = 16 * RPT_UNIT_CYC + 4;
  logic [11:0] run_q;
  wire any_w = |retry_current_o;
  wire oe_w = fault_report_pin_n_oe_o;
  // Consecutive on-cycles of the watched channel
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) run_q <= 12'h000;
    else if (!channel_sink_output_o[5]) run_q <= 12'h000;
    else if (run_q != 12'hfff) run_q <= run_q + 12'h001;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside slot");
  a_pin_only_low: assert property (fault_report_pin_n_o == 1'b0)
    else $error("fault pin driven high");
  a_flag_after_ontime: assert property ($rose(retry_current_o[5]) |-> $past(run_q, 3) >= 12'd2500)
    else $error("flag before full on-time");
  a_pin_set: assert property ($rose(any_w) |-> ##[0:RWIN] (oe_w || !any_w))
    else $error("fault pin not pulled");
  a_pin_free: assert property ($fell(any_w) |-> ##[0:RWIN] (!oe_w || any_w))
    else $error("fault pin not released");
  a_oe_cause: assert property ($rose(oe_w) |-> any_w || $past(any_w))
    else $error("fault pin without fault");
  a_mode_hold: assert property (!$past(reg_wr_i) |-> $stable(string_short_mode_select_o))
    else $error("mode changed without write");
  a_mode_write: assert property (reg_wr_i && reg_addr_i == 8'h4b
    |=> string_short_mode_select_o == $past(reg_wdata_i[2:0]))
    else $error("mode write lost");
  c_fault: cover property ($rose(any_w));
  c_pin: cover property ($rose(oe_w));
  c_clear: cover property ($fell(any_w));
endmodule
bind ldpf_top ldpf_props #(.RPT_UNIT_CYC(RPT_UNIT_CYC)) u_props (
  .mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .channel_sink_output_o, .retry_current_o,
  .string_short_mode_select_o, .fault_report_pin_n_o, .fault_report_pin_n_oe_o);

/* File: dv/ldpf_led_model.sv */
// Purpose: LED strings on the sinks and pull-up on the fault wire
// Assumes: Faults are commanded by the bench per channel
// Notes: Off-phase comparators show the inverse of the fault
module ldpf_led_model (
  input wire [17:0] sink_i,
  input wire [17:0] open_i,
  input wire [17:0] short_i,
  input wire [17:0] sls_i,
  input wire oe_i,
  input wire pin_drv_i,
  output wire [17:0] open_cmp_o,
  output wire [17:0] short_cmp_o,
  output wire [17:0] sls_cmp_o,
  output wire pin_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sink off: the comparator reading is meaningless
  assign open_cmp_o = ~(sink_i ^ open_i);
  assign short_cmp_o = ~(sink_i ^ short_i);
  assign sls_cmp_o = ~(sink_i ^ sls_i);
  assign pin_n_o = oe_i ? pin_drv_i : 1'b1;
endmodule

/* File: dv/ldpf_tb_top.sv */
// Purpose: Self-checking bench for ldpf_top
// Assumes: Report unit shortened to 4 cycles
// Notes: PWM in 7+5 and 8-bit modes, base tick 81 clocks
module ldpf_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 128 * 81;
  logic mclk_i = 0;
  logic sys_rst_i = 1;
  logic [7:0] addr = 0;
  logic [7:0] wdata = 0;
  logic wr = 0;
  logic rd = 0;
  logic sup = 0;
  logic [2:0][17:0] inj = '0;
  wire [7:0] rdata;
  wire [17:0] sink, retry, oc, sc, lc;
  wire [2:0] smode;
  wire [44:0] thr;
  wire pin_n, pin_drv, pin_oe;
  int error_cnt = 0;
  int n_tests = 0;
  always #2 mclk_i = ~mclk_i;
  ldpf_top #(.RPT_UNIT_CYC(4)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .open_cmp_i(oc), .short_cmp_i(sc), .sls_cmp_i(lc),
    .supply_ok_i(sup), .channel_sink_output_o(sink), .retry_current_o(retry),
    .string_short_mode_select_o(smode), .single_short_threshold_code_o(thr),
    .fault_report_pin_n_i(pin_n), .fault_report_pin_n_o(pin_drv),
    .fault_report_pin_n_oe_o(pin_oe));
  ldpf_led_model u_led (.sink_i(sink), .open_i(inj[0]), .short_i(inj[1]),
    .sls_i(inj[2]), .oe_i(pin_oe), .pin_drv_i(pin_drv), .open_cmp_o(oc),
    .short_cmp_o(sc), .sls_cmp_o(lc), .pin_n_o(pin_n));
  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk_i);
    rd <= 1'b0;
    @(negedge mclk_i);
    chk(rdata, e);
  endtask
  task automatic wait_retry(input logic lvl);
    int k;
    k = 0;
    while (retry[5] !== lvl && k < 12000) begin
      @(posedge mclk_i);
      k++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    rdc(8'h00, 8'h00);
    rdc(8'h03, 8'h01);
    wrr(8'h41, 8'h1f);
    wrr(8'h49, 8'h15);
    wrr(8'h4b, 8'h03);
    wrr(8'h4a, 8'h01);
    wrr(8'h26, 8'hab);
    wrr(8'h40, 8'h12);
    wrr(8'hff, 8'h55);
    wrr(8'h4e, 8'hff);
    chk(thr[4:0], 5'h1f);
    chk(thr[44:40], 5'h15);
    chk(smode, 3'h3);
    rdc(8'h41, 8'h1f);
    rdc(8'h4a, 8'h01);
    rdc(8'h26, 8'hab);
    rdc(8'h40, 8'h12);
    rdc(8'hff, 8'h00);
    rdc(8'h4e, 8'h00);
    wrr(8'h4a, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_pwm(input logic [7:0] ph, input logic [7:0] md);
    int r [18];
    int on;
    int pm;
    logic [17:0] pv;
    int ofs [6] = '{0, 1, 3, 4, 6, 7};
    pm = (md == 8'h02) ? 2 * P : P;
    wrr(8'h00, md);
    wrr(8'h03, ph);
    for (int i = 0; i < 27; i++) wrr(8'h26 + i[7:0], (i % 3 == 2) ? 8'h00 : 8'h80);
    repeat (4) @(posedge mclk_i);
    on = 0;
    pv = sink;
    for (int k = 0; k < pm; k++) begin
      @(posedge mclk_i);
      on += sink[0];
      for (int c = 0; c < 18; c++) if (sink[c] && !pv[c]) r[c] = k;
      pv = sink;
    end
    chk(on, (md == 8'h02) ? 128 * 81 : 64 * 81);
    for (int g = 0; g < 6; g++) begin
      chk((r[3*g] - r[0] + pm) % pm, ph[0] ? ofs[g] * pm / 8 : 0);
      chk(r[3*g+2], r[3*g]);
    end
    $display("test pwm done");
  endtask
  task automatic t_fault(input int ty);
    logic [7:0] fa;
    fa = (ty == 0) ? 8'h51 : (ty == 1) ? 8'h4e : 8'h54;
    sup <= (ty != 2);
    for (int i = 0; i < 27; i++) wrr(8'h26 + i[7:0], 8'hff);
    wrr(8'h4d, 8'h01);
    wrr(8'h4c, 8'h01 << (2 * ty));
    inj[ty][5] <= 1'b1;
    repeat (3000) @(posedge mclk_i);
    chk(retry[5], 0);
    wrr(8'h4c, 8'h03 << (2 * ty));
    if (ty == 2) begin
      repeat (3000) @(posedge mclk_i);
      chk(retry[5], 0);
      sup <= 1'b1;
    end
    repeat (2400) @(posedge mclk_i);
    chk(retry[5], 0);
    wait_retry(1'b1);
    chk(retry[5], 1);
    repeat (20) @(posedge mclk_i);
    chk(pin_n, 0);
    rdc(fa, 8'h20);
    rdc(8'h57, 8'h01 << ty);
    inj[ty][5] <= 1'b0;
    wait_retry(1'b0);
    repeat (20) @(posedge mclk_i);
    chk(pin_n, 1);
    rdc(fa, 8'h00);
    rdc(8'h57, 8'h80 | (8'h01 << ty));
    wrr(8'h57, 8'h00);
    rdc(8'h57, 8'h80);
    wrr(8'h4c, 8'h00);
    $display("test fault done");
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_pwm(8'h01, 8'h02);
    t_pwm(8'h00, 8'h01);
    t_pwm(8'h01, 8'h01);
    for (int t = 0; t < 3; t++) t_fault(t);
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge mclk_i);
    error_cnt++;
    wrap_up();
  end
endmodule
